// ==== bench/nfc_dev_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module nfc_dev_model (
  input  wire logic       clk_sys,
  input  wire logic       nand_ce_n,
  input  wire logic       nand_cle,
  input  wire logic       nand_ale,
  input  wire logic       nand_we_n,
  input  wire logic       nand_re_n,
  input  wire logic       nand_wp_n,
  input  wire logic       fail_en,
  input  wire logic [7:0] nand_io_out,
  output var  logic [7:0] nand_io_in,
  output var  logic       rb_low
);
  int          busy = 40;
  int          n_prog = 0;
  int          n_erase = 0;
  int          n_byte = 0;
  int          bad = 0;
  int          acnt = 0;
  logic        we_q = 1'b1;
  logic        f1 = 1'b0;
  logic        pfail = 1'b0;
  logic        pwr = 1'b1;
  logic        win = 1'b0;
  logic [23:0] rowa = 24'h00_0000;
  logic [23:0] rowb = 24'h00_0000;
  logic [7:0]  stv;
  assign stv = {nand_wp_n, busy == 0, 3'h0, f1 & pfail, f1 & pfail, pfail};
  // Idle bus shows the inverse, never a held value
  assign nand_io_in = nand_re_n ? ~stv : stv;
  assign rb_low = busy > 0;
  always @(posedge clk_sys) begin
    we_q <= nand_we_n;
    if (busy > 0) busy <= busy - 1;
    if (busy == 1) pwr <= 1'b0;
    if (nand_we_n && !we_q && !nand_ce_n) begin
      if (nand_cle) begin
        acnt <= 0;
        if (pwr && nand_io_out != 8'h70) bad <= bad + 1;
        if (win && !(nand_io_out inside {8'h70, 8'hF1, 8'hFF, 8'h81})) bad <= bad + 1;
        if (nand_io_out == 8'h11) win <= 1'b1;
        else if (nand_io_out == 8'h81) win <= 1'b0;
        case (nand_io_out)
          8'h11, 8'h15: busy <= busy + 3;
          8'h10, 8'hD0: if (nand_wp_n) begin
            // Last page waits for a running cached cycle
            busy <= busy + 30;
            pfail <= fail_en;
            if (nand_io_out == 8'h10) n_prog <= n_prog + 1;
            else n_erase <= n_erase + 1;
          end
          8'hFF: busy <= 5;
          8'h70: f1 <= 1'b0;
          8'hF1: f1 <= 1'b1;
          default: ;
        endcase
      end else if (nand_ale) begin
        acnt <= acnt + 1;
        if (acnt == 0) rowb <= rowa;
        rowa <= {nand_io_out, rowa[23:8]};
      end else n_byte <= n_byte + 1;
    end
  end
endmodule
`default_nettype wire

// ==== bench/nfc_host_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module nfc_host_bench;
  logic            clk_sys = 1'b0;
  logic            reset = 1'b1;
  logic [7:0]      reg_addr = 8'h00;
  logic [31:0]     reg_wdata = 32'h0000_0000;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic            fail_en = 1'b0;
  logic [31:0]     d;
  logic [31:0]     ir;
  wire logic [31:0] reg_rdata;
  wire logic       irq, nand_ce_n, nand_cle, nand_ale, nand_we_n, nand_re_n;
  wire logic       nand_wp_n, nand_io_oe, rb_low;
  wire logic [7:0] nand_io_out, nand_io_in;
  wire logic       nand_rb_n = rb_low ? 1'b0 : 1'b1;
  int              mismatches = 0;
  int              tests_run = 0;
  int              np;
  int              nbt;
  nfc_host i_dut (.clk_sys, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .nand_ce_n, .nand_cle, .nand_ale, .nand_we_n, .nand_re_n, .nand_wp_n, .nand_io_out,
    .nand_io_oe, .nand_io_in, .nand_rb_n);
  nfc_dev_model i_dev (.clk_sys, .nand_ce_n, .nand_cle, .nand_ale, .nand_we_n, .nand_re_n,
    .nand_wp_n, .fail_en, .nand_io_out, .nand_io_in, .rb_low);
  initial forever #12.5 clk_sys = ~clk_sys;
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Protect level is set first, so it is settled before the start
  task automatic run(input logic [3:0] c, input int nb);
    int s = 0;
    wr(8'h18, 32'h0000_000F);
    wr(8'h00, {27'h0, c, 1'b0});
    wr(8'h00, {27'h0, c, 1'b1});
    for (int i = 0; i < 3000; i++) begin
      rd(8'h14, d);
      if (!d[2] && d[0] && s < nb) begin
        wr(8'h10, 32'(s));
        s++;
      end
      rd(8'h18, ir);
      if (ir[1:0] != 2'b00) break;
    end
    chk("op_end", 32'h1, {31'h0, ir[0] | ir[1]});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_init;
    wr(8'h00, 32'h0000_0001);
    rd(8'h18, d);
    chk("refused", 32'h0000_0008, d & 32'h8);
    rd(8'h0C, d);
    chk("len", 32'h0000_0840, d);
    rd(8'h20, d);
    chk("pages", 32'h0000_0001, d);
    rd(8'h24, d);
    chk("unmapped", 32'h0000_0000, d);
    for (int i = 0; i < 200 && d[1] !== 1'b1; i++) rd(8'h14, d);
    chk("init", 32'h2, d & 32'h2);
  endtask
  task automatic t_irq;
    wr(8'h1C, 32'h0000_0001);
    run(4'hB, 0);
    rd(8'h00, d);
    chk("ctrl", 32'h0000_0016, d);
    rd(8'h14, d);
    chk("status", 32'h0000_00C0, {24'h0, d[15:8]});
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(8'h1C, 32'h0000_0002);
    rd(8'h14, d);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(8'h1C, 32'h0000_0001);
    wr(8'h18, 32'h0000_0001);
    rd(8'h14, d);
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask
  task automatic t_prog(input logic f);
    fail_en <= f;
    np = i_dev.n_prog;
    nbt = i_dev.n_byte;
    wr(8'h0C, 32'h0000_0004);
    wr(8'h04, 32'h0001_2345);
    run(4'h8, 8);
    chk("prog_fail", {31'h0, f}, {31'h0, ir[1]});
    chk("prog_cnt", np + 1, i_dev.n_prog);
    chk("bytes", nbt + 8, i_dev.n_byte);
    chk("row0", 32'h0001_2245, i_dev.rowb);
    chk("row1", 32'h0001_2345, i_dev.rowa);
  endtask
  task automatic t_erase;
    np = i_dev.n_erase;
    run(4'hA, 0);
    chk("erase_fail", 32'h0, {31'h0, ir[1]});
    chk("erase_cnt", np + 1, i_dev.n_erase);
    chk("erase_row0", 32'h0001_2245, i_dev.rowb);
  endtask
  task automatic t_misc;
    np = i_dev.n_prog;
    nbt = i_dev.n_byte;
    wr(8'h20, 32'h0000_0002);
    run(4'h9, 16);
    chk("cache_cnt", np + 1, i_dev.n_prog);
    chk("cache_bytes", nbt + 16, i_dev.n_byte);
    run(4'hC, 0);
    chk("reset_fail", 32'h0, {31'h0, ir[1]});
  endtask
  task automatic t_prot;
    fail_en <= 1'b0;
    np = i_dev.n_prog;
    run(4'h0, 8);
    chk("prot_fail", 32'h1, {31'h0, ir[1]});
    chk("prot_cnt", np, i_dev.n_prog);
    chk("cmd_order", 32'h0, i_dev.bad);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #2_000_000;
    mismatches++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    reset <= 1'b0;
    t_init;
    t_irq;
    t_prog(1'b0);
    t_erase;
    t_misc;
    t_prog(1'b1);
    t_prot;
    stop_test;
  end
endmodule
`default_nettype wire

// ==== bench/nfc_host_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module nfc_host_chk (
  input wire logic       clk_sys,
  input wire logic       reset,
  input wire logic       nand_ce_n,
  input wire logic       nand_cle,
  input wire logic       nand_ale,
  input wire logic       nand_we_n,
  input wire logic       nand_re_n,
  input wire logic       nand_wp_n,
  input wire logic [7:0] nand_io_out,
  input wire logic       nand_io_oe,
  input wire logic       nand_rb_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_WP_HOLD: assert property (!nand_rb_n |=> $stable(nand_wp_n))
    else $error("wp moved while busy");
  AST_STROBES: assert property (!(!nand_we_n && !nand_re_n))
    else $error("both strobes low");
  AST_RD_OE: assert property (!nand_re_n |-> !nand_io_oe)
    else $error("host drives during read");
  AST_LATCH: assert property (!(nand_cle && nand_ale))
    else $error("cle and ale together");
  AST_SETUP: assert property ($fell(nand_we_n) |-> ##1
    ($stable(nand_io_out) && $stable(nand_cle) && $stable(nand_ale)) [*2])
    else $error("bus moved around write strobe");
  AST_WE_LOW: assert property ($fell(nand_we_n) |=> !nand_we_n ##1 nand_we_n)
    else $error("write strobe width");
  AST_BUSY_CMD: assert property ($fell(nand_we_n) && nand_cle && !nand_rb_n
    |-> nand_io_out inside {8'h70, 8'hF1, 8'hFF})
    else $error("command while busy");
  AST_CE: assert property (nand_cle || nand_ale |-> !nand_ce_n)
    else $error("latch without chip enable");
endmodule
bind nfc_host nfc_host_chk i_chk (.clk_sys, .reset, .nand_ce_n, .nand_cle, .nand_ale,
  .nand_we_n, .nand_re_n, .nand_wp_n, .nand_io_out, .nand_io_oe, .nand_rb_n);
`default_nettype wire

// ==== verilog/nfc_cfg.svh ====
`ifndef NFC_CFG_SVH
`define NFC_CFG_SVH
// How it works
// - First plane data closed by dummy program
// - Poll status bit six for ready
// - Second plane data follows plane-input command
// - True program starts both planes together
// - Same row both planes, plane bit differs
// - Only status reads between dummy and input
// - Erase setup twice, one block per plane
// - During power-up only status reads allowed
// - No write-protect change while busy
// - Write-protect stays high until program ends

// Device commands
`define NFC_CMD_PROG_SETUP  8'h80
`define NFC_CMD_PLANE_INPUT 8'h81
`define NFC_CMD_DUMMY_PROG  8'h11
`define NFC_CMD_TRUE_PROG   8'h10
`define NFC_CMD_CACHE_PROG  8'h15
`define NFC_CMD_ERASE_SETUP 8'h60
`define NFC_CMD_ERASE_CONF  8'hD0
`define NFC_CMD_STATUS      8'h70
`define NFC_CMD_PLANE_STAT  8'hF1
`define NFC_CMD_RESET       8'hFF

// Device status bits, plane row bit and page size
`define NFC_ST_FAIL   0
`define NFC_ST_READY  6
`define NFC_ST_WP_N   7
`define NFC_PLANE_ROW_BIT 8
`define NFC_PAGE_BYTES 12'd2112

// Register byte offsets
`define NFC_REG_CTRL   8'h00
`define NFC_REG_ROW    8'h04
`define NFC_REG_COL    8'h08
`define NFC_REG_LEN    8'h0C
`define NFC_REG_DATA   8'h10
`define NFC_REG_STAT   8'h14
`define NFC_REG_IRQ    8'h18
`define NFC_REG_MASK   8'h1C
`define NFC_REG_PAGES  8'h20

// Control fields
`define NFC_CTRL_START 0
`define NFC_CTRL_OP_LO 1
`define NFC_CTRL_OP_HI 3
`define NFC_CTRL_WP_EN 4

// Interrupt bits
`define NFC_IRQ_DONE    0
`define NFC_IRQ_FAIL    1
`define NFC_IRQ_DATAREQ 2
`define NFC_IRQ_REFUSED 3
`define NFC_IRQ_W       4

// Timing
`define NFC_CLK_NS     25
`define NFC_CYCLE_NS   50
`define NFC_TICK_DIV   ((`NFC_CYCLE_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`define NFC_TWB_NS     100
`define NFC_TWB_CYC    ((`NFC_TWB_NS + `NFC_CLK_NS - 1) / `NFC_CLK_NS)
`endif

// ==== verilog/nfc_cyc_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface nfc_cyc_if;
  import nfc_pkg::*;
  logic      req;
  nfc_kind_e kind;
  logic [7:0] wbyte;
  logic      done;
  logic [7:0] rbyte;
  modport master (output req, kind, wbyte, input done, rbyte);
  modport engine (input req, kind, wbyte, output done, rbyte);
endinterface
`default_nettype wire

// ==== verilog/nfc_host.sv ====
// The implementer's own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "nfc_cfg.svh"
module nfc_host
  import nfc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output var  logic [31:0] reg_rdata,
  output var  logic        irq,
  output var  logic        nand_ce_n,
  output var  logic        nand_cle,
  output var  logic        nand_ale,
  output var  logic        nand_we_n,
  output var  logic        nand_re_n,
  output var  logic        nand_wp_n,
  output var  logic [7:0]  nand_io_out,
  output var  logic        nand_io_oe,
  input  wire logic [7:0]  nand_io_in,
  input  wire logic        nand_rb_n
);
  localparam logic [7:0] TWB_LAST = 8'(`NFC_TWB_CYC - 1);

  nfc_cyc_if cyc ();
  logic tick;

  nfc_tick_div u_div (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (tick)
  );

  // Ready/busy is an input only: the host never drives it
  nfc_pin_cycle u_pins (
    .clk_sys (clk_sys),
    .reset   (reset),
    .tick    (tick),
    .cyc     (cyc),
    .cle     (nand_cle),
    .ale     (nand_ale),
    .we_n    (nand_we_n),
    .re_n    (nand_re_n),
    .io_out  (nand_io_out),
    .io_oe   (nand_io_oe),
    .io_in   (nand_io_in)
  );

  function automatic logic [23:0] plane_row(input logic [23:0] row, input logic plane);
    logic [23:0] r;
    r = row;
    r[`NFC_PLANE_ROW_BIT] = plane;
    return r;
  endfunction

  function automatic logic [7:0] addr_byte(input logic [2:0] idx, input logic [15:0] col,
                                           input logic [23:0] row);
    unique case (idx)
      3'd0:    return col[7:0];
      3'd1:    return col[15:8];
      3'd2:    return row[7:0];
      3'd3:    return row[15:8];
      default: return row[23:16];
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and interrupts

  nfc_op_e    op_reg, op_next;
  logic [23:0] row_reg, row_next;
  logic [15:0] col_reg, col_next;
  logic [11:0] len_reg, len_next;
  logic [7:0]  pages_cfg_reg, pages_cfg_next;
  logic        wp_en_reg, wp_en_next;
  logic [7:0]  data_reg, data_next;
  logic        data_full_reg, data_full_next;
  logic [3:0]  irq_stat_reg, irq_stat_next;
  logic [3:0]  mask_reg, mask_next;
  logic [31:0] rdata_next;
  logic        irq_next;
  logic        start, data_take;
  logic [3:0]  ev;

  nfc_state_e  st_reg, st_next;
  logic [7:0]  dev_stat_reg, dev_stat_next;
  logic        init_done_reg, init_done_next;

  always_comb begin
    op_next = op_reg;
    row_next = row_reg;
    col_next = col_reg;
    len_next = len_reg;
    pages_cfg_next = pages_cfg_reg;
    wp_en_next = wp_en_reg;
    data_next = data_reg;
    mask_next = mask_reg;
    start = 1'b0;
    data_full_next = data_full_reg & ~data_take;
    irq_stat_next = irq_stat_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        `NFC_REG_CTRL: begin
          start = reg_wdata[`NFC_CTRL_START];
          wp_en_next = reg_wdata[`NFC_CTRL_WP_EN];
          if (reg_wdata[`NFC_CTRL_START] && st_reg == ST_IDLE)
            op_next = nfc_op_e'(reg_wdata[`NFC_CTRL_OP_HI:`NFC_CTRL_OP_LO]);
        end
        `NFC_REG_ROW:   row_next = reg_wdata[23:0];
        `NFC_REG_COL:   col_next = reg_wdata[15:0];
        `NFC_REG_LEN:   len_next = reg_wdata[11:0];
        `NFC_REG_PAGES: pages_cfg_next = reg_wdata[7:0];
        `NFC_REG_DATA: begin
          data_next = reg_wdata[7:0];
          data_full_next = 1'b1;
        end
        `NFC_REG_IRQ:   irq_stat_next = irq_stat_reg & ~reg_wdata[3:0];
        `NFC_REG_MASK:  mask_next = reg_wdata[3:0];
        default: ;
      endcase
    end
    // New events win over a same-cycle clear
    irq_stat_next = irq_stat_next | ev;
    irq_next = |(irq_stat_next & mask_next);
    rdata_next = 32'h0000_0000;
    if (reg_rd) begin
      unique case (reg_addr)
        `NFC_REG_CTRL:  rdata_next = {27'h0, wp_en_reg, op_reg, 1'b0};
        `NFC_REG_ROW:   rdata_next = {8'h00, row_reg};
        `NFC_REG_COL:   rdata_next = {16'h0000, col_reg};
        `NFC_REG_LEN:   rdata_next = {20'h0_0000, len_reg};
        `NFC_REG_PAGES: rdata_next = {24'h00_0000, pages_cfg_reg};
        `NFC_REG_STAT:  rdata_next = {16'h0000, dev_stat_reg, 4'h0, nand_rb_n,
                                      data_full_reg, init_done_reg, st_reg != ST_IDLE};
        `NFC_REG_IRQ:   rdata_next = {28'h000_0000, irq_stat_reg};
        `NFC_REG_MASK:  rdata_next = {28'h000_0000, mask_reg};
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      op_reg <= OP_PROG;
      row_reg <= 24'h00_0000;
      col_reg <= 16'h0000;
      len_reg <= `NFC_PAGE_BYTES;
      pages_cfg_reg <= 8'h01;
      wp_en_reg <= 1'b0;
      data_reg <= 8'h00;
      data_full_reg <= 1'b0;
      irq_stat_reg <= 4'h0;
      mask_reg <= 4'h0;
      reg_rdata <= 32'h0000_0000;
      irq <= 1'b0;
    end else begin
      op_reg <= op_next;
      row_reg <= row_next;
      col_reg <= col_next;
      len_reg <= len_next;
      pages_cfg_reg <= pages_cfg_next;
      wp_en_reg <= wp_en_next;
      data_reg <= data_next;
      data_full_reg <= data_full_next;
      irq_stat_reg <= irq_stat_next;
      mask_reg <= mask_next;
      reg_rdata <= rdata_next;
      irq <= irq_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer

  logic        plane_reg, plane_next;
  logic [11:0] idx_reg, idx_next;
  logic [7:0]  pages_reg, pages_next;
  logic        issued_reg, issued_next;
  logic [7:0]  twb_reg, twb_next;
  logic        wp_n_next, ce_n_next, req_next;
  nfc_kind_e   kind_next;
  logic [7:0]  wbyte_next;
  logic        is_erase, last_addr, more_pages;

  always_comb begin
    is_erase = (op_reg == OP_ERASE);
    // Erase sends row cycles only, program sends column and row
    last_addr = is_erase ? (idx_reg == 12'd4) : (idx_reg == 12'd4);
    more_pages = (op_reg == OP_CACHE) && (pages_reg > 8'h01);
  end

  // Issue one pin cycle, then advance on its completion
  always_comb begin
    st_next = st_reg;
    plane_next = plane_reg;
    idx_next = idx_reg;
    pages_next = pages_reg;
    issued_next = issued_reg;
    twb_next = twb_reg;
    dev_stat_next = dev_stat_reg;
    init_done_next = init_done_reg;
    wp_n_next = nand_wp_n;
    ce_n_next = nand_ce_n;
    req_next = 1'b0;
    kind_next = cyc.kind;
    wbyte_next = cyc.wbyte;
    data_take = 1'b0;
    ev = 4'h0;
    if (!issued_reg && st_reg != ST_IDLE && st_reg != ST_TWB && st_reg != ST_PWR_TWB &&
        st_reg != ST_WAIT_RB && !(st_reg == ST_DATA && !data_full_reg)) begin
      req_next = 1'b1;
      issued_next = 1'b1;
    end
    // Early start is refused in every power-up state, not only in idle
    if (start && !init_done_reg) ev[`NFC_IRQ_REFUSED] = 1'b1;
    unique case (st_reg)
      ST_PWR_TWB: begin
        twb_next = twb_reg + 8'h01;
        if (twb_reg == TWB_LAST) st_next = ST_PWR_CMD;
      end
      ST_PWR_CMD: begin
        kind_next = K_CMD;
        wbyte_next = `NFC_CMD_STATUS;
        if (cyc.done) begin
          issued_next = 1'b0;
          st_next = ST_PWR_RD;
        end
      end
      ST_PWR_RD: begin
        kind_next = K_RDATA;
        if (cyc.done) begin
          issued_next = 1'b0;
          dev_stat_next = cyc.rbyte;
          if (cyc.rbyte[`NFC_ST_READY]) begin
            init_done_next = 1'b1;
            st_next = ST_IDLE;
          end else begin
            st_next = ST_PWR_CMD;
          end
        end
      end
      ST_IDLE: begin
        ce_n_next = 1'b1;
        // Protect line only moves while no operation runs
        wp_n_next = wp_en_reg;
        if (start && init_done_reg) begin
          ce_n_next = 1'b0;
          plane_next = 1'b0;
          idx_next = is_erase ? 12'd2 : 12'd0;
          pages_next = (op_next == OP_CACHE && pages_cfg_reg != 8'h00) ? pages_cfg_reg : 8'h01;
          unique case (op_next)
            OP_STATUS: st_next = ST_STAT_CMD;
            OP_RESET:  st_next = ST_RST_CMD;
            default:   st_next = ST_SETUP;
          endcase
          if (op_next == OP_ERASE) idx_next = 12'd2;
          else idx_next = 12'd0;
        end
      end
      ST_SETUP: begin
        kind_next = K_CMD;
        if (is_erase) wbyte_next = `NFC_CMD_ERASE_SETUP;
        else if (plane_reg) wbyte_next = `NFC_CMD_PLANE_INPUT;
        else wbyte_next = `NFC_CMD_PROG_SETUP;
        if (cyc.done) begin
          issued_next = 1'b0;
          st_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        kind_next = K_ADDR;
        // Second plane reuses the first row, only the plane bit flips
        wbyte_next = addr_byte(idx_reg[2:0], col_reg, plane_row(row_reg, plane_reg));
        if (cyc.done) begin
          issued_next = 1'b0;
          idx_next = idx_reg + 12'd1;
          if (last_addr) begin
            idx_next = 12'd0;
            if (is_erase && !plane_reg) begin
              plane_next = 1'b1;
              idx_next = 12'd2;
              st_next = ST_SETUP;
            end else if (is_erase) begin
              st_next = ST_CONF;
            end else begin
              st_next = ST_DATA;
            end
          end
        end
      end
      ST_DATA: begin
        kind_next = K_WDATA;
        wbyte_next = data_reg;
        if (!issued_reg && data_full_reg) data_take = 1'b1;
        if (!issued_reg && !data_full_reg) ev[`NFC_IRQ_DATAREQ] = 1'b1;
        if (cyc.done) begin
          issued_next = 1'b0;
          idx_next = idx_reg + 12'd1;
          if (idx_reg + 12'd1 >= len_reg) st_next = ST_CONF;
        end
      end
      ST_CONF: begin
        kind_next = K_CMD;
        if (is_erase) wbyte_next = `NFC_CMD_ERASE_CONF;
        else if (!plane_reg) wbyte_next = `NFC_CMD_DUMMY_PROG;
        else if (more_pages) wbyte_next = `NFC_CMD_CACHE_PROG;
        else wbyte_next = `NFC_CMD_TRUE_PROG;
        if (cyc.done) begin
          issued_next = 1'b0;
          twb_next = 8'h00;
          // Dummy busy is short: poll status, never wait for an array time
          st_next = (!is_erase && !plane_reg) ? ST_POLL_CMD : ST_TWB;
        end
      end
      ST_POLL_CMD: begin
        kind_next = K_CMD;
        wbyte_next = `NFC_CMD_STATUS;
        if (cyc.done) begin
          issued_next = 1'b0;
          st_next = ST_POLL_RD;
        end
      end
      ST_POLL_RD: begin
        kind_next = K_RDATA;
        if (cyc.done) begin
          issued_next = 1'b0;
          dev_stat_next = cyc.rbyte;
          if (cyc.rbyte[`NFC_ST_READY]) begin
            plane_next = 1'b1;
            idx_next = 12'd0;
            st_next = ST_SETUP;
          end else begin
            st_next = ST_POLL_CMD;
          end
        end
      end
      ST_TWB: begin
        twb_next = twb_reg + 8'h01;
        if (twb_reg == TWB_LAST) st_next = ST_WAIT_RB;
      end
      ST_WAIT_RB: if (nand_rb_n) begin
        st_next = (op_reg == OP_RESET) ? ST_IDLE : ST_STAT_CMD;
        if (op_reg == OP_RESET) ev[`NFC_IRQ_DONE] = 1'b1;
      end
      ST_STAT_CMD: begin
        kind_next = K_CMD;
        wbyte_next = (op_reg == OP_STATUS) ? `NFC_CMD_STATUS : `NFC_CMD_PLANE_STAT;
        if (cyc.done) begin
          issued_next = 1'b0;
          st_next = ST_STAT_RD;
        end
      end
      ST_STAT_RD: begin
        kind_next = K_RDATA;
        if (cyc.done) begin
          issued_next = 1'b0;
          dev_stat_next = cyc.rbyte;
          // Chip bit covers both pages; protected means nothing was written
          if (op_reg != OP_STATUS && (cyc.rbyte[`NFC_ST_FAIL] || !cyc.rbyte[`NFC_ST_WP_N]))
            ev[`NFC_IRQ_FAIL] = 1'b1;
          if (more_pages && cyc.rbyte[`NFC_ST_WP_N]) begin
            pages_next = pages_reg - 8'h01;
            plane_next = 1'b0;
            idx_next = 12'd0;
            st_next = ST_SETUP;
          end else begin
            ev[`NFC_IRQ_DONE] = 1'b1;
            st_next = ST_IDLE;
          end
        end
      end
      ST_RST_CMD: begin
        kind_next = K_CMD;
        wbyte_next = `NFC_CMD_RESET;
        if (cyc.done) begin
          issued_next = 1'b0;
          twb_next = 8'h00;
          st_next = ST_TWB;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= ST_PWR_TWB;
      plane_reg <= 1'b0;
      idx_reg <= 12'h000;
      pages_reg <= 8'h01;
      issued_reg <= 1'b0;
      twb_reg <= 8'h00;
      dev_stat_reg <= 8'h00;
      init_done_reg <= 1'b0;
      nand_wp_n <= 1'b0;
      nand_ce_n <= 1'b0;
      cyc.req <= 1'b0;
      cyc.kind <= K_CMD;
      cyc.wbyte <= 8'h00;
    end else begin
      st_reg <= st_next;
      plane_reg <= plane_next;
      idx_reg <= idx_next;
      pages_reg <= pages_next;
      issued_reg <= issued_next;
      twb_reg <= twb_next;
      dev_stat_reg <= dev_stat_next;
      init_done_reg <= init_done_next;
      nand_wp_n <= wp_n_next;
      nand_ce_n <= ce_n_next;
      cyc.req <= req_next;
      cyc.kind <= kind_next;
      cyc.wbyte <= wbyte_next;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/nfc_pin_cycle.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nfc_cfg.svh"
module nfc_pin_cycle
  import nfc_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic       tick,
  nfc_cyc_if.engine       cyc,
  output var  logic       cle,
  output var  logic       ale,
  output var  logic       we_n,
  output var  logic       re_n,
  output var  logic [7:0] io_out,
  output var  logic       io_oe,
  input  wire logic [7:0] io_in
);
  nfc_eng_e   st_reg, st_next;
  logic       rd_reg, rd_next;
  logic       cle_next, ale_next, we_n_next, re_n_next, oe_next, done_next;
  logic [7:0] out_next, rbyte_next;

  always_comb begin
    st_next = st_reg;
    rd_next = rd_reg;
    cle_next = cle;
    ale_next = ale;
    we_n_next = we_n;
    re_n_next = re_n;
    oe_next = io_oe;
    out_next = io_out;
    rbyte_next = cyc.rbyte;
    done_next = 1'b0;
    unique case (st_reg)
      EN_IDLE: if (cyc.req) begin
        st_next = EN_SETUP;
        rd_next = (cyc.kind == K_RDATA);
        cle_next = (cyc.kind == K_CMD);
        ale_next = (cyc.kind == K_ADDR);
        oe_next = (cyc.kind != K_RDATA);
        out_next = cyc.wbyte;
      end
      EN_SETUP: if (tick) begin
        st_next = EN_LOW;
        we_n_next = rd_reg;
        re_n_next = !rd_reg;
      end
      EN_LOW: if (tick) begin
        // Sample just before the read strobe rises
        st_next = EN_HOLD;
        we_n_next = 1'b1;
        re_n_next = 1'b1;
        if (rd_reg) rbyte_next = io_in;
      end
      EN_HOLD: if (tick) begin
        st_next = EN_IDLE;
        cle_next = 1'b0;
        ale_next = 1'b0;
        oe_next = 1'b0;
        done_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      st_reg <= EN_IDLE;
      rd_reg <= 1'b0;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_oe <= 1'b0;
      io_out <= 8'h00;
      cyc.rbyte <= 8'h00;
      cyc.done <= 1'b0;
    end else begin
      st_reg <= st_next;
      rd_reg <= rd_next;
      cle <= cle_next;
      ale <= ale_next;
      we_n <= we_n_next;
      re_n <= re_n_next;
      io_oe <= oe_next;
      io_out <= out_next;
      cyc.rbyte <= rbyte_next;
      cyc.done <= done_next;
    end
  end
endmodule
`default_nettype wire

// ==== verilog/nfc_pkg.sv ====
package nfc_pkg;
  typedef enum logic [1:0] {K_CMD, K_ADDR, K_WDATA, K_RDATA} nfc_kind_e;
  typedef enum logic [2:0] {OP_PROG, OP_CACHE, OP_ERASE, OP_STATUS, OP_RESET} nfc_op_e;
  typedef enum {
    ST_PWR_TWB, ST_PWR_CMD, ST_PWR_RD, ST_IDLE, ST_SETUP, ST_ADDR, ST_DATA, ST_CONF,
    ST_TWB, ST_WAIT_RB, ST_POLL_CMD, ST_POLL_RD, ST_STAT_CMD, ST_STAT_RD, ST_RST_CMD
  } nfc_state_e;
  typedef enum {EN_IDLE, EN_SETUP, EN_LOW, EN_HOLD} nfc_eng_e;
endpackage

// ==== verilog/nfc_tick_div.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "nfc_cfg.svh"
module nfc_tick_div
  import nfc_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic reset,
  output var  logic tick
);
  localparam logic [7:0] LAST = 8'(`NFC_TICK_DIV - 1);
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic       tick_next;

  always_comb begin
    tick_next = (cnt_reg == LAST);
    cnt_next  = tick_next ? 8'h00 : cnt_reg + 8'h01;
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cnt_reg <= 8'h00;
      tick    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick    <= tick_next;
    end
  end
endmodule
`default_nettype wire
